// >>> src/hkd_pkg.sv
// shared constants for the headset key event detector
package hkd_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_EVENT     = 8'h04;
   localparam logic [7:0] ADDR_ADC       = 8'h08;
   localparam logic [7:0] ADDR_THRESH    = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'h14;
   localparam logic [7:0] ADDR_IRQ_CLR   = 8'h18;
   localparam logic [7:0] ADDR_DEBOUNCE  = 8'h1c;
   // control register bit positions
   localparam int CTRL_ENABLE  = 0;
   localparam int CTRL_RAW     = 1;
   localparam int CTRL_TRIGGER = 2;
   // event register layout: press bits 3:0, release bits 7:4, conversion bit 8
   localparam int EV_REL_LSB   = 4;
   localparam int EV_CONV      = 8;
   localparam int EV_W         = 9;
   localparam int NUM_KEYS     = 4;
   // interrupt status layout
   localparam int IRQ_PRESS    = 0;
   localparam int IRQ_RELEASE  = 1;
   localparam int IRQ_CONV     = 2;
   localparam int IRQ_W        = 3;
   // reset values
   localparam logic [7:0]  THRESH_RST  = 8'h40;
   localparam logic [15:0] DEB_PRESS_RST = 16'h0064;
   localparam logic [15:0] DEB_REL_RST   = 16'h0064;
   localparam logic [7:0]  ADC_CLEARED = 8'h00;
   localparam logic [7:0]  ADC_MIN     = 8'h01;
   // bus responses
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   // converter timing
   localparam int ADC_BITS     = 8;
endpackage

// >>> src/hkd_adc.sv
// successive-approximation converter sequencer for the mic line level
`timescale 1ns/1ps
`default_nettype none
module hkd_adc #(
   parameter int WIDTH = hkd_pkg::ADC_BITS
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             start,
   input  wire logic             cmp_hi,
   output logic [WIDTH-1:0]      dac_code,
   output logic                  done,
   output logic [WIDTH-1:0]      result
);
   typedef struct packed {
      logic             busy;
      logic [WIDTH-1:0] code;
      logic [WIDTH-1:0] bitmask;
      logic             done;
      logic [WIDTH-1:0] result;
   } hkd_adc_s;

   hkd_adc_s s_r;
   hkd_adc_s s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (start && !s_r.busy)
      begin
         s_nxt.busy = 1'b1;
         s_nxt.bitmask = {1'b1, {(WIDTH-1){1'b0}}};
         s_nxt.code = {1'b1, {(WIDTH-1){1'b0}}};
      end
      else if (s_r.busy)
      begin
         // keep the trial bit when the line is above the trial level
         if (!cmp_hi)
            s_nxt.code = s_r.code & ~s_r.bitmask;
         if (s_r.bitmask[0])
         begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            // a finished conversion never reads as zero
            if ((s_nxt.code) == '0)
               s_nxt.result = WIDTH'(hkd_pkg::ADC_MIN);
            else
               s_nxt.result = s_nxt.code;
         end
         else
         begin
            s_nxt.bitmask = s_r.bitmask >> 1;
            s_nxt.code = s_nxt.code | (s_r.bitmask >> 1);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign dac_code = s_r.code;
   assign done     = s_r.done;
   assign result   = s_r.result;
endmodule // hkd_adc
`default_nettype wire

// >>> src/hkd_top.sv
// headset key event detector with debounce, event flags, converter and axi4-lite registers
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - line below threshold starts press debounce
// - glitch before period end restarts debounce
// - debounce end sets press flag, interrupt
// - press flag set clears same release flag
// - host read of events clears, drops interrupt unless enabled status pends
// - key release starts release debounce
// - release debounce end sets release flag
// - unread flags accumulate across key events
// - enable written zero stops, clears flags
// - raw mode set keeps pending flags
// - raw mode reports via key 1 only
// - enable written zero clears raw mode
// - adc output clears only on listed causes
// - manual trigger reconverts, no press flag
// - every conversion updates output, sets flag
// - converted value nonzero, zero means none
// - disable or removal zeroes event register
module hkd_top #(
   parameter int NKEYS = hkd_pkg::NUM_KEYS
) (
   input  wire logic        CLK_SYS,
   input  wire logic        SRST,
   input  wire logic        MIC_BELOW,
   input  wire logic        MIC_CMP_HI,
   input  wire logic        REMOVAL,
   output logic [7:0]       MIC_DAC_CODE,
   output logic             IRQ,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);
   // ==========================================================
   // types and state
   typedef enum logic [1:0] {ST_IDLE, ST_PRESS_DEB, ST_HELD, ST_REL_DEB} hkd_key_e;

   typedef struct packed {
      logic [1:0]                   sync_below;
      logic [1:0]                   sync_removal;
      logic                         removal_d;
      hkd_key_e                     key_st;
      logic [15:0]                  deb_cnt;
      logic                         enable;
      logic                         raw;
      logic                         conv_is_key;
      logic [7:0]                   thresh;
      logic [15:0]                  deb_press;
      logic [15:0]                  deb_rel;
      logic [hkd_pkg::EV_W-1:0]     events;
      logic [7:0]                   adc_out;
      logic [1:0]                   cur_key;
      logic [hkd_pkg::IRQ_W-1:0]    irq_stat;
      logic [hkd_pkg::IRQ_W-1:0]    irq_en;
      logic                         irq;
      logic                         adc_start;
      logic                         aw_got;
      logic                         w_got;
      logic [7:0]                   aw_addr;
      logic [31:0]                  w_data;
      logic [3:0]                   w_strb;
      logic                         bvalid;
      logic [1:0]                   bresp;
      logic                         rvalid;
      logic [31:0]                  rdata;
      logic [1:0]                   rresp;
   } hkd_top_s;

   hkd_top_s s_r;
   hkd_top_s s_nxt;

   logic [7:0] adc_code;
   logic       adc_done;
   logic [7:0] adc_result;

   // ==========================================================
   // converter
   hkd_adc #(
      .WIDTH (hkd_pkg::ADC_BITS)
   ) u_adc (
      .clk      (CLK_SYS),
      .srst     (SRST),
      .start    (s_r.adc_start),
      .cmp_hi   (MIC_CMP_HI),
      .dac_code (adc_code),
      .done     (adc_done),
      .result   (adc_result)
   );

   // ==========================================================
   // next state
   always_comb
   begin
      logic        wr_fire;
      logic        rd_fire;
      logic        below;
      logic        removal_ev;
      logic        disable_ev;
      logic [2:0]  key_idx;
      logic [hkd_pkg::IRQ_W-1:0] set_irq;
      logic [31:0] wd;
      wr_fire    = 1'b0;
      rd_fire    = 1'b0;
      below      = 1'b0;
      removal_ev = 1'b0;
      disable_ev = 1'b0;
      key_idx    = '0;
      set_irq    = '0;
      wd         = '0;

      s_nxt = s_r;
      s_nxt.adc_start = 1'b0;
      s_nxt.sync_below   = {s_r.sync_below[0], MIC_BELOW};
      s_nxt.sync_removal = {s_r.sync_removal[0], REMOVAL};
      s_nxt.removal_d    = s_r.sync_removal[1];
      below      = s_r.sync_below[1];
      removal_ev = s_r.sync_removal[1] && !s_r.removal_d;

      // ---- axi write channel: address and data in either order
      if (S_AXI_AWVALID && !s_r.aw_got)
      begin
         s_nxt.aw_got  = 1'b1;
         s_nxt.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !s_r.w_got)
      begin
         s_nxt.w_got  = 1'b1;
         s_nxt.w_data = S_AXI_WDATA;
         s_nxt.w_strb = S_AXI_WSTRB;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
         s_nxt.bvalid = 1'b0;
      wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
      wd = s_r.w_data;

      // ---- key debounce state machine
      if (s_r.enable)
      begin
         case (s_r.key_st)
            ST_IDLE:
            begin
               if (below)
               begin
                  s_nxt.key_st  = ST_PRESS_DEB;
                  s_nxt.deb_cnt = '0;
               end
            end
            ST_PRESS_DEB:
            begin
               if (!below)
                  s_nxt.key_st = ST_IDLE;
               else if (s_r.deb_cnt >= s_r.deb_press)
               begin
                  s_nxt.key_st      = ST_HELD;
                  s_nxt.adc_start   = 1'b1;
                  s_nxt.conv_is_key = 1'b1;
               end
               else
                  s_nxt.deb_cnt = s_r.deb_cnt + 16'h0001;
            end
            ST_HELD:
            begin
               if (!below)
               begin
                  s_nxt.key_st  = ST_REL_DEB;
                  s_nxt.deb_cnt = '0;
               end
            end
            default:
            begin
               if (below)
                  s_nxt.key_st = ST_HELD;
               else if (s_r.deb_cnt >= s_r.deb_rel)
               begin
                  s_nxt.key_st = ST_IDLE;
                  key_idx = s_r.raw ? 3'h0 : {1'b0, s_r.cur_key};
                  s_nxt.events[hkd_pkg::EV_REL_LSB + int'(key_idx)] = 1'b1;
                  set_irq[hkd_pkg::IRQ_RELEASE] = 1'b1;
               end
               else
                  s_nxt.deb_cnt = s_r.deb_cnt + 16'h0001;
            end
         endcase
      end

      // ---- conversion result: key binning or raw report
      if (adc_done)
      begin
         s_nxt.adc_out = adc_result;
         s_nxt.events[hkd_pkg::EV_CONV] = 1'b1;
         set_irq[hkd_pkg::IRQ_CONV] = 1'b1;
         if (s_r.conv_is_key)
         begin
            // raw mode ignores the threshold and folds every key onto key 1
            if (s_r.raw)
               key_idx = 3'h0;
            else if (adc_result < s_r.thresh)
               key_idx = 3'h0;
            // widened so the doubled and quadrupled bin edges keep their carry bits
            else if ({2'b00, adc_result} < {1'b0, s_r.thresh, 1'b0})
               key_idx = 3'h1;
            else if ({2'b00, adc_result} < {s_r.thresh, 2'b00})
               key_idx = 3'h2;
            else
               key_idx = 3'h3;
            s_nxt.cur_key = key_idx[1:0];
            s_nxt.events[int'(key_idx)] = 1'b1;
            s_nxt.events[hkd_pkg::EV_REL_LSB + int'(key_idx)] = 1'b0;
            set_irq[hkd_pkg::IRQ_PRESS] = 1'b1;
         end
         s_nxt.conv_is_key = 1'b0;
      end

      // ---- register writes
      if (wr_fire)
      begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = hkd_pkg::RESP_OKAY;
         if (!s_r.w_strb[0])
            s_nxt.bresp = hkd_pkg::RESP_OKAY;
         else if (s_r.aw_addr == hkd_pkg::ADDR_CTRL)
         begin
            s_nxt.enable = wd[hkd_pkg::CTRL_ENABLE];
            // raw bit only sticks while detection is on; setting it keeps flags
            s_nxt.raw = wd[hkd_pkg::CTRL_RAW] && wd[hkd_pkg::CTRL_ENABLE];
            disable_ev = !wd[hkd_pkg::CTRL_ENABLE];
            if (s_r.raw && !wd[hkd_pkg::CTRL_RAW])
               s_nxt.adc_out = hkd_pkg::ADC_CLEARED;
            // trigger only while a debounced press is still held
            if (wd[hkd_pkg::CTRL_TRIGGER] && s_r.enable && s_r.key_st == ST_HELD)
            begin
               s_nxt.adc_start   = 1'b1;
               s_nxt.conv_is_key = 1'b0;
            end
         end
         else if (s_r.aw_addr == hkd_pkg::ADDR_THRESH)
            s_nxt.thresh = wd[7:0];
         else if (s_r.aw_addr == hkd_pkg::ADDR_IRQ_EN)
            s_nxt.irq_en = wd[hkd_pkg::IRQ_W-1:0];
         else if (s_r.aw_addr == hkd_pkg::ADDR_IRQ_CLR)
            s_nxt.irq_stat = s_nxt.irq_stat & ~wd[hkd_pkg::IRQ_W-1:0];
         else if (s_r.aw_addr == hkd_pkg::ADDR_DEBOUNCE)
         begin
            s_nxt.deb_press = wd[15:0];
            s_nxt.deb_rel   = wd[31:16];
         end
         else
            s_nxt.bresp = hkd_pkg::RESP_SLVERR;
      end

      // ---- register reads
      if (S_AXI_RVALID && S_AXI_RREADY)
         s_nxt.rvalid = 1'b0;
      rd_fire = S_AXI_ARVALID && !s_r.rvalid;
      if (rd_fire)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = hkd_pkg::RESP_OKAY;
         s_nxt.rdata  = '0;
         if (S_AXI_ARADDR == hkd_pkg::ADDR_CTRL)
         begin
            s_nxt.rdata[hkd_pkg::CTRL_ENABLE] = s_r.enable;
            s_nxt.rdata[hkd_pkg::CTRL_RAW]    = s_r.raw;
         end
         else if (S_AXI_ARADDR == hkd_pkg::ADDR_EVENT)
         begin
            s_nxt.rdata[hkd_pkg::EV_W-1:0] = s_r.events;
            // read clears, but flags raised this same cycle survive
            s_nxt.events = s_nxt.events & ~s_r.events;
         end
         else if (S_AXI_ARADDR == hkd_pkg::ADDR_ADC)
            s_nxt.rdata[7:0] = s_r.adc_out;
         else if (S_AXI_ARADDR == hkd_pkg::ADDR_THRESH)
            s_nxt.rdata[7:0] = s_r.thresh;
         else if (S_AXI_ARADDR == hkd_pkg::ADDR_IRQ_STAT)
            s_nxt.rdata[hkd_pkg::IRQ_W-1:0] = s_r.irq_stat;
         else if (S_AXI_ARADDR == hkd_pkg::ADDR_IRQ_EN)
            s_nxt.rdata[hkd_pkg::IRQ_W-1:0] = s_r.irq_en;
         else if (S_AXI_ARADDR == hkd_pkg::ADDR_IRQ_CLR)
            s_nxt.rdata = '0;
         else if (S_AXI_ARADDR == hkd_pkg::ADDR_DEBOUNCE)
            s_nxt.rdata = {s_r.deb_rel, s_r.deb_press};
         else
            s_nxt.rresp = hkd_pkg::RESP_SLVERR;
      end

      // ---- disable or accessory removal wipes detection state
      if (disable_ev || removal_ev)
      begin
         s_nxt.events      = '0;
         s_nxt.adc_out     = hkd_pkg::ADC_CLEARED;
         s_nxt.key_st      = ST_IDLE;
         s_nxt.conv_is_key = 1'b0;
         s_nxt.adc_start   = 1'b0;
         if (removal_ev)
         begin
            s_nxt.raw = 1'b0;
            s_nxt.enable = 1'b0;
         end
      end

      // sticky status, set wins over clear
      s_nxt.irq_stat = s_nxt.irq_stat | set_irq;
      // pin follows both pending events and enabled status
      s_nxt.irq = (|s_nxt.events) || (|(s_nxt.irq_stat & s_nxt.irq_en));
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         s_r           <= '0;
         s_r.key_st    <= ST_IDLE;
         s_r.thresh    <= hkd_pkg::THRESH_RST;
         s_r.deb_press <= hkd_pkg::DEB_PRESS_RST;
         s_r.deb_rel   <= hkd_pkg::DEB_REL_RST;
      end
      else
         s_r <= s_nxt;
   end

   // ==========================================================
   // outputs
   // trial code is already a flop in the converter; a second stage would make
   // the comparator judge the previous trial
   assign MIC_DAC_CODE  = adc_code;
   assign IRQ           = s_r.irq;
   assign S_AXI_AWREADY = !s_r.aw_got;
   assign S_AXI_WREADY  = !s_r.w_got;
   assign S_AXI_BVALID  = s_r.bvalid;
   assign S_AXI_BRESP   = s_r.bresp;
   assign S_AXI_ARREADY = !s_r.rvalid;
   assign S_AXI_RVALID  = s_r.rvalid;
   assign S_AXI_RDATA   = s_r.rdata;
   assign S_AXI_RRESP   = s_r.rresp;
endmodule // hkd_top
`default_nettype wire

// >>> verif/hkd_line_model.sv
// behavioural model of the headset mic line and its comparators
`timescale 1ns/1ps
`default_nettype none
module hkd_line_model (
   input  wire logic       clk,
   input  wire logic       held,
   input  wire logic [7:0] lvl,
   input  wire logic [7:0] dac,
   output logic            below,
   output logic            cmp_hi
);
   // ==========
   // line state
   // an idle line sits at bias, so it is never below threshold
   always_ff @(posedge clk)
   begin
      below <= held;
   end
   // idle line is above every trial level the converter can try
   assign cmp_hi = held ? (lvl > dac) : 1'b1;
endmodule // hkd_line_model
`default_nettype wire

// >>> verif/hkd_top_props.sv
// concurrent checks on the ports of the key event detector
`timescale 1ns/1ps
`default_nettype none
module hkd_top_props #(
   parameter int NKEYS = hkd_pkg::NUM_KEYS
) (
   input wire logic       CLK_SYS,
   input wire logic       SRST,
   input wire logic       MIC_BELOW,
   input wire logic       IRQ,
   input wire logic       S_AXI_AWVALID,
   input wire logic       S_AXI_AWREADY,
   input wire logic       S_AXI_WVALID,
   input wire logic       S_AXI_WREADY,
   input wire logic       S_AXI_BVALID,
   input wire logic       S_AXI_BREADY,
   input wire logic       S_AXI_ARVALID,
   input wire logic       S_AXI_ARREADY,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic       S_AXI_RVALID,
   input wire logic       S_AXI_RREADY
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);
   // ==========
   // key timing
   // sync plus debounce means no flag can appear this soon
   press_quiet_a: assert property ($rose(MIC_BELOW) && !IRQ |=> !IRQ [*4])
      else $error("interrupt too soon after line dropped");
   release_quiet_a: assert property ($fell(MIC_BELOW) && !IRQ |=> !IRQ [*4])
      else $error("interrupt too soon after line rose");
   // ==========
   // register bus
   write_resp_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
      else $error("write response late");
   read_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read data late");
   bresp_once_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write response repeated");
   rresp_once_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read data repeated");
   ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("address taken while data pending");
   aw_block_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
      else $error("write address taken twice");
   cover property ($rose(IRQ));
   cover property (S_AXI_RVALID && S_AXI_RRESP == hkd_pkg::RESP_SLVERR);
   cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule // hkd_top_props
bind hkd_top hkd_top_props #(.NKEYS(NKEYS)) hkd_top_props_i (.*);
`default_nettype wire

// >>> verif/hkd_top_tb.sv
// self-checking bench for the headset key event detector
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module hkd_top_tb;
   logic        CLK_SYS = 1'b0;
   logic        SRST = 1'b1;
   logic        MIC_BELOW;
   logic        MIC_CMP_HI;
   logic        REMOVAL = 1'b0;
   logic [7:0]  MIC_DAC_CODE;
   logic        IRQ;
   logic [7:0]  S_AXI_AWADDR = 8'h00;
   logic        S_AXI_AWVALID = 1'b0;
   logic        S_AXI_AWREADY;
   logic [31:0] S_AXI_WDATA = 32'h0;
   logic [3:0]  S_AXI_WSTRB = 4'hf;
   logic        S_AXI_WVALID = 1'b0;
   logic        S_AXI_WREADY;
   logic [1:0]  S_AXI_BRESP;
   logic        S_AXI_BVALID;
   logic        S_AXI_BREADY = 1'b1;
   logic [7:0]  S_AXI_ARADDR = 8'h00;
   logic        S_AXI_ARVALID = 1'b0;
   logic        S_AXI_ARREADY;
   logic [31:0] S_AXI_RDATA;
   logic [1:0]  S_AXI_RRESP;
   logic        S_AXI_RVALID;
   logic        S_AXI_RREADY = 1'b1;
   logic        held = 1'b0;
   logic [7:0]  lvl = 8'h20;
   logic [31:0] rd;
   logic [31:0] adc1;
   logic [1:0]  rr;
   logic [1:0]  br;
   int          n_mismatch = 0;
   int          check_count = 0;
   always #20 CLK_SYS = ~CLK_SYS;
   hkd_top hkd_top_i (.*);
   hkd_line_model hkd_line_model_i (.clk(CLK_SYS), .held(held), .lvl(lvl),
      .dac(MIC_DAC_CODE), .below(MIC_BELOW), .cmp_hi(MIC_CMP_HI));
   // ==========
   // tasks
   task automatic give_verdict;
      if (n_mismatch == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge CLK_SYS);
   endtask
   // ready lines stay high, so each task is free to start at the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      do
      begin
         @(posedge CLK_SYS);
         if (S_AXI_AWVALID && S_AXI_AWREADY)
            S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WVALID && S_AXI_WREADY)
            S_AXI_WVALID <= 1'b0;
         n++;
         if (n > 100)
         begin
            n_mismatch++;
            give_verdict();
         end
      end
      while (!S_AXI_BVALID);
      br = S_AXI_BRESP;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      int n;
      n = 0;
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do
      begin
         @(posedge CLK_SYS);
         if (S_AXI_ARVALID && S_AXI_ARREADY)
            S_AXI_ARVALID <= 1'b0;
         n++;
         if (n > 100)
         begin
            n_mismatch++;
            give_verdict();
         end
      end
      while (!S_AXI_RVALID);
      rd = S_AXI_RDATA;
      rr = S_AXI_RRESP;
   endtask
   task automatic ckr(input logic [7:0] a, input logic [31:0] w);
      rd_reg(a);
      `CK(rr, hkd_pkg::RESP_OKAY)
      `CK(rd, w)
   endtask
   task automatic wirq(input logic v);
      int n;
      n = 0;
      while (IRQ !== v && n < 400)
      begin
         @(posedge CLK_SYS);
         n++;
      end
      `CK(IRQ, v)
      if (IRQ !== v)
         give_verdict();
   endtask
   // debounce is cut to 8 cycles, so 40 covers sync, debounce and conversion
   task automatic press(input logic [7:0] l);
      lvl <= l;
      held <= 1'b1;
      tick(40);
   endtask
   task automatic rel;
      held <= 1'b0;
      tick(40);
   endtask
   // ==========
   // main sequence
   initial
   begin
      tick(5);
      SRST <= 1'b0;
      tick(1);
      ckr(hkd_pkg::ADDR_CTRL, 32'h0);
      ckr(hkd_pkg::ADDR_EVENT, 32'h0);
      ckr(hkd_pkg::ADDR_ADC, 32'h0);
      ckr(hkd_pkg::ADDR_THRESH, 32'h40);
      ckr(hkd_pkg::ADDR_DEBOUNCE, 32'h0064_0064);
      rd_reg(8'h20);
      `CK(rr, hkd_pkg::RESP_SLVERR)
      wr(8'h20, 32'h0);
      `CK(br, hkd_pkg::RESP_SLVERR)
      wr(hkd_pkg::ADDR_DEBOUNCE, 32'h0008_0008);
      `CK(br, hkd_pkg::RESP_OKAY)
      wr(hkd_pkg::ADDR_IRQ_EN, 32'h0);
      wr(hkd_pkg::ADDR_CTRL, 32'h1);
      repeat (2)
      begin
         held <= 1'b1;
         tick(6);
         held <= 1'b0;
         tick(2);
      end
      `CK(IRQ, 1'b0)
      held <= 1'b1;
      wirq(1'b1);
      ckr(hkd_pkg::ADDR_EVENT, 32'h101);
      wirq(1'b0);
      ckr(hkd_pkg::ADDR_EVENT, 32'h0);
      held <= 1'b0;
      wirq(1'b1);
      ckr(hkd_pkg::ADDR_EVENT, 32'h10);
      press(8'h20);
      rel();
      press(8'h60);
      rel();
      press(8'h20);
      ckr(hkd_pkg::ADDR_EVENT, 32'h123);
      wr(hkd_pkg::ADDR_CTRL, 32'h5);
      tick(30);
      `CK(MIC_DAC_CODE, 8'h1f)
      ckr(hkd_pkg::ADDR_EVENT, 32'h100);
      rd_reg(hkd_pkg::ADDR_ADC);
      `CK(rd[7:0] != 8'h00, 1'b1)
      rel();
      press(8'h60);
      wr(hkd_pkg::ADDR_CTRL, 32'h3);
      ckr(hkd_pkg::ADDR_EVENT, 32'h112);
      rel();
      rd_reg(hkd_pkg::ADDR_EVENT);
      press(8'h60);
      ckr(hkd_pkg::ADDR_EVENT, 32'h101);
      rd_reg(hkd_pkg::ADDR_ADC);
      adc1 = rd;
      ckr(hkd_pkg::ADDR_ADC, adc1);
      rel();
      ckr(hkd_pkg::ADDR_EVENT, 32'h10);
      wr(hkd_pkg::ADDR_CTRL, 32'h1);
      ckr(hkd_pkg::ADDR_ADC, 32'h0);
      // a level past twice the threshold lands in the third bin
      press(8'hc0);
      rel();
      ckr(hkd_pkg::ADDR_EVENT, 32'h144);
      wr(hkd_pkg::ADDR_CTRL, 32'h3);
      press(8'h20);
      wr(hkd_pkg::ADDR_CTRL, 32'h0);
      ckr(hkd_pkg::ADDR_CTRL, 32'h0);
      ckr(hkd_pkg::ADDR_EVENT, 32'h0);
      ckr(hkd_pkg::ADDR_ADC, 32'h0);
      `CK(IRQ, 1'b0)
      rel();
      ckr(hkd_pkg::ADDR_EVENT, 32'h0);
      wr(hkd_pkg::ADDR_CTRL, 32'h1);
      press(8'h20);
      REMOVAL <= 1'b1;
      tick(4);
      REMOVAL <= 1'b0;
      tick(4);
      ckr(hkd_pkg::ADDR_EVENT, 32'h0);
      ckr(hkd_pkg::ADDR_ADC, 32'h0);
      rel();
      wr(hkd_pkg::ADDR_IRQ_CLR, 32'h7);
      ckr(hkd_pkg::ADDR_IRQ_STAT, 32'h0);
      wr(hkd_pkg::ADDR_CTRL, 32'h1);
      wr(hkd_pkg::ADDR_IRQ_EN, 32'h1);
      press(8'h20);
      ckr(hkd_pkg::ADDR_IRQ_STAT, 32'h5);
      ckr(hkd_pkg::ADDR_EVENT, 32'h101);
      `CK(IRQ, 1'b1)
      wr(hkd_pkg::ADDR_IRQ_EN, 32'h0);
      wirq(1'b0);
      wr(hkd_pkg::ADDR_IRQ_EN, 32'h1);
      wirq(1'b1);
      wr(hkd_pkg::ADDR_IRQ_CLR, 32'h1);
      wirq(1'b0);
      ckr(hkd_pkg::ADDR_IRQ_STAT, 32'h4);
      ckr(hkd_pkg::ADDR_IRQ_CLR, 32'h0);
      give_verdict();
   end
endmodule // hkd_top_tb
`default_nettype wire
